// file: core/acs_defines.svh
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// Register byte offsets on the register bus.
`define ACS_OFS_CTRL  8'h00
`define ACS_OFS_STAT  8'h04
`define ACS_OFS_CUR   8'h08
`define ACS_OFS_NEXT  8'h0c
`define ACS_OFS_EXT0  8'h30
`define ACS_OFS_EXT1  8'h34
`define ACS_OFS_EXT2  8'h38
// Fetched descriptor words read back at 0x40 plus four times the word index.
`define ACS_DESC_WIN  3'h2

// Field positions.
`define ACS_CTRL_EN   0
`define ACS_CTRL_RES  1
`define ACS_ST_MABORT 5
`define ACS_ST_EOT    8
`define ACS_ST_EOC    9
`define ACS_ST_ACTIVE 10
`define ACS_DC_IE     0
`define ACS_DC_DWE    31

// Descriptor layout for four sources, eight words.
`define ACS_DESC_WORDS 8
`define ACS_W_NDA     3'h0
`define ACS_W_BC      3'h6
`define ACS_W_CTL     3'h7
`define ACS_W_LAST    3'h7

// Alignment mask and reset values.
`define ACS_ADDR_MASK 32'hffff_ffe0
`define ACS_RST_WORD  32'h0000_0000
`define ACS_RST_CTRL  2'h0

`endif

// file: core/acs_pkg.sv
`default_nettype none

package acs_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_EXEC,
    ST_XFER,
    ST_DONE,
    ST_LINK
  } acs_state_t;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
  } acs_mrd_req_t;

  typedef struct packed {
    logic        ack;
    logic        mabort;
    logic        tabort;
    logic [31:0] rdata;
  } acs_mrd_rsp_t;

  typedef struct packed {
    logic        start;
    logic        hold;
    logic        dwe;
    logic [31:0] desc_addr;
  } acs_xfer_cmd_t;

  typedef struct packed {
    logic done;
    logic mabort;
    logic tabort;
  } acs_xfer_rsp_t;

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lane_mask

  function automatic logic [31:0] merge_lanes(input logic [31:0] old,
                                              input logic [31:0] din,
                                              input logic [3:0]  sel);
    merge_lanes = (old & ~lane_mask(sel)) | (din & lane_mask(sel));
  endfunction : merge_lanes

  function automatic logic [31:0] word_addr(input logic [31:0] base,
                                            input logic [2:0]  idx);
    word_addr = base + {27'h0, idx, 2'h0};
  endfunction : word_addr

endpackage : acs_pkg

`default_nettype wire

// file: core/acs_desc_mem.sv
`include "acs_defines.svh"
`default_nettype none

module acs_desc_mem (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Write side, filled by descriptor fetch.
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_addr,
  input  wire logic [31:0] wr_data,
  // Read side, registered.
  input  wire logic [2:0]  rd_addr,
  output logic      [31:0] rd_data
);

  logic [31:0] mem [`ACS_DESC_WORDS];

  // Cleared on reset so that the read-only copies show defaults.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < `ACS_DESC_WORDS; i++)
      begin
        mem[i] <= `ACS_RST_WORD;
      end
      rd_data <= `ACS_RST_WORD;
    end
    else
    begin
      if (wr_en)
      begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end

endmodule : acs_desc_mem

`default_nettype wire

// file: core/acs_accel_ctrl.sv
// How it works
// RULE_01: Completion raises the interrupt only when the descriptor's done-interrupt bit is set.
// RULE_02: One interrupt output carries completion and error interrupts alike.
// RULE_03: Once enabled, the descriptor is fetched and its words loaded into registers.
// RULE_04: With data write clear, processing writes no destination, then reports completion.
// RULE_05: Skip case, no link, no resume: active clears, end-of-chain set, others cleared.
// RULE_06: Skip case with link or resume: active stays, end-of-transfer set, chain continues.
// RULE_07: End-of-transfer and end-of-chain set only with the done-interrupt bit.
// RULE_08: Completion flags appear only after error-free processing; errors may stack.
// RULE_09: A bus master abort sets status bit 5 and interrupts regardless.
// RULE_10: A target abort sets no flag and raises no interrupt.
// RULE_11: Any error stops the current descriptor and clears the active flag.
// RULE_12: After an error no further descriptor is fetched.
// RULE_13: No restart after an error until software enables again.
// RULE_14: Software disables before clearing memory errors, then writes enable 1.
// RULE_15: Reset returns every register to its default.
// RULE_16: Only control, status, next address and extended controls are writable.
// RULE_17: Control register stays readable and writable while active.
// RULE_18: Current address register holds the descriptor being processed, read-only.
// RULE_19: Software aligns descriptors to their source-count boundary.
// RULE_20: Next address holds the first descriptor; low five bits forced to zero.
// RULE_21: Software writes next address only while disabled and inactive.
// RULE_22: Software checks the active flag before servicing an error interrupt.
// RULE_23: Enable with resume re-reads the last descriptor's link and continues.
// RULE_24: Clearing enable suspends the transfer in place; setting it resumes.
// RULE_25: Interrupt stays asserted while any status flag is set.
`include "acs_defines.svh"
`default_nettype none

module acs_accel_ctrl
  import acs_pkg::*;
(
  // Clock and reset.
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  // Wishbone register slave.
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  // Descriptor reads from local memory.
  output var acs_mrd_req_t   mem_req_o,
  input  wire acs_mrd_rsp_t  mem_rsp_i,
  // Data mover.
  output var acs_xfer_cmd_t  xfer_cmd_o,
  input  wire acs_xfer_rsp_t xfer_rsp_i,
  // Interrupt.
  output logic               accel_irq
);

  logic [1:0]  accel_control_reg;
  logic        start_req;
  logic        active;
  logic        flag_mabort;
  logic        flag_eot;
  logic        flag_eoc;
  logic [31:0] current_desc_addr_reg;
  logic [31:0] next_desc_addr_reg;
  logic [31:0] ext_desc_control_0;
  logic [31:0] ext_desc_control_1;
  logic [31:0] ext_desc_control_2;
  logic [31:0] desc_nda;
  logic [31:0] desc_bc;
  logic [31:0] desc_control_word;
  logic [2:0]  word_idx;
  logic        wb_wait;
  logic        xfer_start;
  logic [31:0] mem_rdata;
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  acs_state_t  state;

  // Bus decode.
  wire logic        wb_req    = wb_cyc_i & wb_stb_i;
  wire logic        wr        = wb_ack_o & wb_req & wb_we_i;
  wire logic        hit_ctrl  = wb_adr_i == `ACS_OFS_CTRL;
  wire logic        hit_stat  = wb_adr_i == `ACS_OFS_STAT;
  wire logic        hit_cur   = wb_adr_i == `ACS_OFS_CUR;
  wire logic        hit_next  = wb_adr_i == `ACS_OFS_NEXT;
  wire logic        hit_ext0  = wb_adr_i == `ACS_OFS_EXT0;
  wire logic        hit_ext1  = wb_adr_i == `ACS_OFS_EXT1;
  wire logic        hit_ext2  = wb_adr_i == `ACS_OFS_EXT2;
  wire logic        hit_desc  = wb_adr_i[7:5] == `ACS_DESC_WIN;
  wire logic [31:0] wmask     = lane_mask(wb_sel_i);
  wire logic [31:0] ctrl_wr   = merge_lanes({30'h0, accel_control_reg}, wb_dat_i, wb_sel_i);
  wire logic [31:0] w1c       = (wr & hit_stat) ? (wb_dat_i & wmask) : `ACS_RST_WORD;

  // Control decode.
  wire logic        enable          = accel_control_reg[`ACS_CTRL_EN];
  wire logic        resume          = accel_control_reg[`ACS_CTRL_RES];
  wire logic        irq_on_done_bit = desc_control_word[`ACS_DC_IE];
  wire logic        mem_live        = mem_req_o.req;
  wire logic        mem_hit         = mem_live & mem_rsp_i.ack;
  wire logic        in_xfer         = state == ST_XFER;
  wire logic        in_done         = state == ST_DONE;
  wire logic        fault_ma        = (mem_live & mem_rsp_i.mabort)
                                    | (in_xfer & xfer_rsp_i.mabort);
  wire logic        fault_ta        = (mem_live & mem_rsp_i.tabort)
                                    | (in_xfer & xfer_rsp_i.tabort);
  wire logic        fault           = fault_ma | fault_ta;
  wire logic [31:0] nda_masked      = desc_nda & `ACS_ADDR_MASK;
  wire logic [31:0] link_masked     = mem_rsp_i.rdata & `ACS_ADDR_MASK;
  wire logic        has_link        = nda_masked != `ACS_RST_WORD;
  wire logic        chain_more      = has_link | resume;
  wire logic        set_eot         = in_done & chain_more & irq_on_done_bit;
  wire logic        set_eoc         = in_done & ~chain_more & irq_on_done_bit;
  wire logic        end_chain       = in_done & ~chain_more;
  wire logic        go              = (state == ST_IDLE) & start_req & enable;
  wire logic        link_hit        = (state == ST_LINK) & mem_hit;

  // Suspension withholds new reads; an answer arriving while suspended is dropped and the word read again.
  assign mem_req_o  = {((state == ST_FETCH) | (state == ST_LINK)) & enable, // RULE_24
                       word_addr(current_desc_addr_reg, word_idx)};
  assign xfer_cmd_o = {xfer_start, ~enable, desc_control_word[`ACS_DC_DWE], // RULE_04 RULE_24
                       current_desc_addr_reg};
  assign accel_irq            = flag_mabort | flag_eot | flag_eoc; // RULE_02 RULE_25

  acs_desc_mem u_desc_mem (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .wr_en    ((state == ST_FETCH) & mem_hit), // RULE_03
    .wr_addr  (word_idx),
    .wr_data  (mem_rsp_i.rdata),
    .rd_addr  (wb_adr_i[4:2]),
    .rd_data  (mem_rdata)
  );

  always_comb
  begin
    status_word                 = `ACS_RST_WORD;
    status_word[`ACS_ST_MABORT] = flag_mabort;
    status_word[`ACS_ST_EOT]    = flag_eot;
    status_word[`ACS_ST_EOC]    = flag_eoc;
    status_word[`ACS_ST_ACTIVE] = active;
  end

  always_comb
  begin
    if (hit_ctrl)
      rd_mux = {30'h0, accel_control_reg}; // RULE_17
    else if (hit_stat)
      rd_mux = status_word;
    else if (hit_cur)
      rd_mux = current_desc_addr_reg;
    else if (hit_next)
      rd_mux = next_desc_addr_reg;
    else if (hit_ext0)
      rd_mux = ext_desc_control_0;
    else if (hit_ext1)
      rd_mux = ext_desc_control_1;
    else if (hit_ext2)
      rd_mux = ext_desc_control_2;
    else if (hit_desc)
      rd_mux = mem_rdata;
    else
      rd_mux = `ACS_RST_WORD;
  end

  // Two-cycle answer leaves a cycle for the registered descriptor copy.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wb_wait  <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= `ACS_RST_WORD;
    end
    else
    begin
      wb_wait  <= wb_req & ~wb_wait & ~wb_ack_o;
      wb_ack_o <= wb_wait;
      if (wb_wait)
      begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  // Start is only armed from idle, so a stale enable never restarts a chain.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      accel_control_reg <= `ACS_RST_CTRL; // RULE_15
      start_req         <= 1'b0;
    end
    else if (wr & hit_ctrl)
    begin
      accel_control_reg <= ctrl_wr[1:0]; // RULE_17
      start_req         <= ctrl_wr[`ACS_CTRL_EN] & (state == ST_IDLE); // RULE_23
    end
    else
    begin
      if (fault)
      begin
        accel_control_reg[`ACS_CTRL_EN] <= 1'b0; // RULE_13
      end
      if (link_hit)
      begin
        accel_control_reg[`ACS_CTRL_RES] <= 1'b0;
      end
      if (go)
      begin
        start_req <= 1'b0;
      end
    end
  end

  // Hardware set wins over a software clear in the same cycle.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flag_mabort <= 1'b0;
      flag_eot    <= 1'b0;
      flag_eoc    <= 1'b0;
    end
    else
    begin
      flag_mabort <= fault_ma | (flag_mabort & ~w1c[`ACS_ST_MABORT] & ~end_chain); // RULE_09
      flag_eot    <= set_eot | (flag_eot & ~w1c[`ACS_ST_EOT] & ~end_chain); // RULE_06 RULE_07
      flag_eoc    <= set_eoc | (flag_eoc & ~w1c[`ACS_ST_EOC]); // RULE_05 RULE_01 RULE_08
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ext_desc_control_0 <= `ACS_RST_WORD;
      ext_desc_control_1 <= `ACS_RST_WORD;
      ext_desc_control_2 <= `ACS_RST_WORD;
    end
    else if (wr)
    begin
      if (hit_ext0)
        ext_desc_control_0 <= merge_lanes(ext_desc_control_0, wb_dat_i, wb_sel_i); // RULE_16
      if (hit_ext1)
        ext_desc_control_1 <= merge_lanes(ext_desc_control_1, wb_dat_i, wb_sel_i);
      if (hit_ext2)
        ext_desc_control_2 <= merge_lanes(ext_desc_control_2, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state                 <= ST_IDLE;
      active                <= 1'b0;
      word_idx              <= `ACS_W_NDA;
      current_desc_addr_reg <= `ACS_RST_WORD;
      next_desc_addr_reg    <= `ACS_RST_WORD;
      desc_nda              <= `ACS_RST_WORD;
      desc_bc               <= `ACS_RST_WORD;
      desc_control_word     <= `ACS_RST_WORD;
      xfer_start            <= 1'b0;
    end
    else
    begin
      xfer_start <= 1'b0;
      if (wr & hit_next)
      begin
        next_desc_addr_reg <= merge_lanes(next_desc_addr_reg, wb_dat_i, wb_sel_i); // RULE_16
      end
      if (fault)
      begin
        state  <= ST_IDLE; // RULE_11 RULE_12
        active <= 1'b0; // RULE_11
      end
      else
      begin
        case (state)
          ST_IDLE:
          begin
            if (go)
            begin
              active   <= 1'b1;
              word_idx <= `ACS_W_NDA;
              if (resume)
              begin
                state <= ST_LINK; // RULE_23
              end
              else
              begin
                current_desc_addr_reg <= next_desc_addr_reg & `ACS_ADDR_MASK; // RULE_20
                next_desc_addr_reg    <= next_desc_addr_reg & `ACS_ADDR_MASK;
                state                 <= ST_FETCH; // RULE_03
              end
            end
          end
          ST_FETCH:
          begin
            if (mem_hit)
            begin
              if (word_idx == `ACS_W_NDA)
              begin
                desc_nda           <= mem_rsp_i.rdata; // RULE_03
                next_desc_addr_reg <= link_masked; // RULE_20
              end
              if (word_idx == `ACS_W_BC)
                desc_bc <= mem_rsp_i.rdata;
              if (word_idx == `ACS_W_CTL)
                desc_control_word <= mem_rsp_i.rdata;
              word_idx <= word_idx + 3'h1;
              if (word_idx == `ACS_W_LAST)
                state <= ST_EXEC;
            end
          end
          ST_EXEC:
          begin
            if (desc_bc == `ACS_RST_WORD)
            begin
              state <= ST_DONE; // RULE_05 RULE_06
            end
            else
            begin
              xfer_start <= 1'b1; // RULE_04
              state      <= ST_XFER;
            end
          end
          ST_XFER:
          begin
            if (xfer_rsp_i.done)
              state <= ST_DONE;
          end
          ST_DONE:
          begin
            if (!chain_more)
            begin
              active <= 1'b0; // RULE_05
              state  <= ST_IDLE;
            end
            else if (has_link)
            begin
              current_desc_addr_reg <= nda_masked; // RULE_18
              word_idx              <= `ACS_W_NDA;
              state                 <= ST_FETCH; // RULE_06
            end
            else
            begin
              state <= ST_LINK; // RULE_23
            end
          end
          ST_LINK:
          begin
            if (mem_hit)
            begin
              if (link_masked == `ACS_RST_WORD)
              begin
                active <= 1'b0;
                state  <= ST_IDLE;
              end
              else
              begin
                current_desc_addr_reg <= link_masked; // RULE_18 RULE_23
                next_desc_addr_reg    <= link_masked;
                word_idx              <= `ACS_W_NDA;
                state                 <= ST_FETCH;
              end
            end
          end
          default:
          begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_last_word;
    state == ST_FETCH && mem_hit && word_idx == `ACS_W_LAST;
  endsequence

  sequence s_fault_idle;
    fault ##1 !start_req;
  endsequence

  property p_fetch_exec;
    s_last_word |=> state == ST_EXEC;
  endproperty
  a_fetch_exec: assert property (p_fetch_exec) // RULE_03
    else $error("Last descriptor word did not lead to execute.");

  property p_ma_irq;
    fault_ma |=> flag_mabort && accel_irq;
  endproperty
  a_ma_irq: assert property (p_ma_irq) // RULE_09
    else $error("Master abort did not set its flag and interrupt.");

  property p_ta_quiet;
    fault_ta && !fault_ma && !accel_irq |=> !accel_irq;
  endproperty
  a_ta_quiet: assert property (p_ta_quiet) // RULE_10
    else $error("Target abort raised the interrupt.");

  property p_err_stop;
    fault |=> state == ST_IDLE && !active;
  endproperty
  a_err_stop: assert property (p_err_stop) // RULE_11
    else $error("Error did not stop the engine and clear active.");

  property p_no_refetch;
    s_fault_idle |-> !mem_req_o.req;
  endproperty
  a_no_refetch: assert property (p_no_refetch) // RULE_12
    else $error("Descriptor read issued after an error.");

  property p_no_restart;
    state == ST_IDLE && !start_req |=> state == ST_IDLE;
  endproperty
  a_no_restart: assert property (p_no_restart) // RULE_13
    else $error("Engine left idle without a start.");

  property p_eoc;
    end_chain && irq_on_done_bit |=> flag_eoc && !flag_eot && !flag_mabort && !active;
  endproperty
  a_eoc: assert property (p_eoc) // RULE_05
    else $error("End of chain flags wrong.");

  property p_eot;
    set_eot |=> flag_eot && active && accel_irq;
  endproperty
  a_eot: assert property (p_eot) // RULE_06
    else $error("End of transfer flags wrong.");

  property p_quiet_ie;
    in_done && !irq_on_done_bit && !flag_eot && !flag_eoc |=> !flag_eot && !flag_eoc;
  endproperty
  a_quiet_ie: assert property (p_quiet_ie) // RULE_07
    else $error("Completion flag set with interrupt bit clear.");

  property p_first_addr;
    go && !resume |=> current_desc_addr_reg == ($past(next_desc_addr_reg) & `ACS_ADDR_MASK);
  endproperty
  a_first_addr: assert property (p_first_addr) // RULE_20
    else $error("First descriptor address not taken from next address.");

  property p_dwe;
    $rose(xfer_cmd_o.start) |-> state == ST_XFER
                                && xfer_cmd_o.dwe == desc_control_word[`ACS_DC_DWE]
                                && desc_bc != `ACS_RST_WORD;
  endproperty
  a_dwe: assert property (p_dwe) // RULE_04
    else $error("Transfer started with wrong write enable or zero count.");

  property p_suspend;
    !enable && state == ST_FETCH |=> $stable(word_idx);
  endproperty
  a_suspend: assert property (p_suspend) // RULE_24
    else $error("Fetch advanced while suspended.");

  property p_irq_hold;
    flag_eoc && !w1c[`ACS_ST_EOC] |=> accel_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) // RULE_25
    else $error("Interrupt dropped while a flag was still set.");

endmodule : acs_accel_ctrl

`default_nettype wire

// file: verification/acs_mem_model.sv
`default_nettype none

module acs_mem_model
  import acs_pkg::*;
(
  // Clock and reset.
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  // Local memory side.
  input  wire acs_mrd_req_t  mem_req,
  output var acs_mrd_rsp_t   mem_rsp,
  // Data mover side.
  input  wire acs_xfer_cmd_t xfer_cmd,
  output var acs_xfer_rsp_t  xfer_rsp,
  // Latency and faults.
  input  wire logic [3:0]    lat,
  input  wire logic [1:0]    mem_err,
  input  wire logic [1:0]    mv_err
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [0:255];
  logic [3:0]  cnt;
  logic [5:0]  mc;
  logic        busy;
  wire         open = !(mem_rsp.ack || mem_rsp.mabort || mem_rsp.tabort);
  wire         hit = mem_req.req && open && cnt >= lat;
  wire         bad = hit && mem_req.addr[4:2] == 3'h3 && mem_err != 2'h0;

  // Idle data is inverted each cycle so a stale word never passes for an answer.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mem_rsp <= '0;
      cnt <= 4'h0;
    end
    else
    begin
      cnt <= (mem_req.req && !hit) ? cnt + 4'h1 : 4'h0;
      mem_rsp.ack <= hit && !bad;
      mem_rsp.mabort <= bad && mem_err == 2'h1;
      mem_rsp.tabort <= bad && mem_err == 2'h2;
      mem_rsp.rdata <= hit ? mem[mem_req.addr[9:2]] : ~mem_rsp.rdata;
    end
  end

  // Hold freezes the count, as a paused mover would.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy <= 1'b0;
      mc <= 6'h0;
      xfer_rsp <= '0;
    end
    else
    begin
      xfer_rsp <= '0;
      busy <= xfer_cmd.start || (busy && !(mc == {lat, 2'h0} && !xfer_cmd.hold));
      mc <= xfer_cmd.start ? 6'h0 : (busy && !xfer_cmd.hold) ? mc + 6'h1 : mc;
      if (busy && !xfer_cmd.start && !xfer_cmd.hold && mc == {lat, 2'h0})
      begin
        xfer_rsp.done <= mv_err == 2'h0;
        xfer_rsp.mabort <= mv_err == 2'h1;
        xfer_rsp.tabort <= mv_err == 2'h2;
      end
    end
  end
endmodule : acs_mem_model

`default_nettype wire

// file: verification/accel_chain_status_irq_control_bench.sv
`default_nettype none

module accel_chain_status_irq_control_bench
  import acs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic          core_clk = 1'b0, reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]    adr = 8'h00;
  logic [3:0]    sel = 4'h0, lat = 4'h1;
  logic [1:0]    mem_err = 2'h0, mv_err = 2'h0;
  logic [31:0]   dat = 32'h0, dat_o, rd, st, cur;
  logic          ack, irq;
  acs_mrd_req_t  mreq;
  acs_mrd_rsp_t  mrsp;
  acs_xfer_cmd_t xcmd;
  acs_xfer_rsp_t xrsp;
  int            err_count = 0, samples_checked = 0;
  logic [7:0]    regs [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h30, 8'h34, 8'h38, 8'h20, 8'h40};

  acs_accel_ctrl i_dut (
    .core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .mem_req_o(mreq), .mem_rsp_i(mrsp), .xfer_cmd_o(xcmd), .xfer_rsp_i(xrsp), .accel_irq(irq));
  acs_mem_model i_mem (
    .core_clk(core_clk), .reset_n(reset_n), .mem_req(mreq), .mem_rsp(mrsp), .xfer_cmd(xcmd),
    .xfer_rsp(xrsp), .lat(lat), .mem_err(mem_err), .mv_err(mv_err));

  initial
  begin
    forever #10 core_clk = ~core_clk;
  end

  task finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (ack !== 1'b1 && n < 40);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 40)
    begin
      err_count++;
      finish_test();
    end
  endtask : wb

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(rd, exp);
  endtask : rdchk

  // Polls the active flag; a chain that never ends counts as a mismatch.
  task wait_idle;
    int n;
    n = 0;
    do
    begin
      wb(1'b0, 8'h04, 32'h0, 4'hf);
      n++;
    end
    while (rd[10] !== 1'b0 && n < 300);
    if (n >= 300)
    begin
      err_count++;
      finish_test();
    end
  endtask : wait_idle

  task desc(input logic [31:0] a, input logic [31:0] ln, input logic [31:0] bc,
            input logic [31:0] ctl);
    for (int i = 0; i < 8; i++)
      i_mem.mem[a[9:2] + i] = $urandom;
    i_mem.mem[a[9:2]] = ln;
    i_mem.mem[a[9:2] + 6] = bc;
    i_mem.mem[a[9:2] + 7] = ctl;
  endtask : desc

  task start(input logic [31:0] a);
    wb(1'b1, 8'h00, 32'h0, 4'hf);
    wb(1'b1, 8'h0c, a, 4'hf);
    wb(1'b1, 8'h00, 32'h1, 4'hf);
  endtask : start

  // Reference walk of a chain of skip descriptors.
  function automatic void walk(input logic [31:0] a);
    logic [31:0] ctl;
    st = 32'h0;
    for (int i = 0; i < 8; i++)
    begin
      cur = a & 32'hffff_ffe0;
      ctl = i_mem.mem[cur[9:2] + 7];
      a = i_mem.mem[cur[9:2]];
      if (a == 32'h0)
      begin
        st = {22'h0, ctl[0], 9'h0};
        break;
      end
      st[8] = st[8] | ctl[0];
    end
  endfunction : walk

  initial
  begin
    int n;
    void'($urandom(67718));
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    foreach (regs[i]) rdchk(regs[i], 32'h0);
    chk({31'h0, irq}, 32'h0);
    st = $urandom;
    wb(1'b1, 8'h30, st, 4'hf);
    rdchk(8'h30, st);
    wb(1'b1, 8'h34, st, 4'h5);
    rdchk(8'h34, st & 32'h00ff_00ff);
    wb(1'b1, 8'h08, st, 4'hf);
    rdchk(8'h08, 32'h0);
    wb(1'b1, 8'h44, st, 4'hf);
    rdchk(8'h44, 32'h0);
    lat <= 4'($urandom % 4);
    desc(32'h100, 32'h200, 32'h0, 32'h1);
    desc(32'h200, 32'h0, 32'h0, 32'h1);
    start(32'h107);
    wait_idle();
    walk(32'h107);
    rdchk(8'h04, st);
    rdchk(8'h08, cur);
    rdchk(8'h44, i_mem.mem[8'h81]);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, 8'h04, 32'hffff_ffff, 4'hf);
    @(negedge core_clk);
    chk({31'h0, irq}, 32'h0);
    i_mem.mem[8'h47] = 32'h0;
    i_mem.mem[8'h87] = 32'h0;
    start(32'h100);
    wait_idle();
    walk(32'h100);
    rdchk(8'h04, st);
    chk({31'h0, irq}, 32'h0);
    lat <= 4'hf;
    desc(32'h100, 32'h0, 32'h40, 32'h8000_0001);
    start(32'h100);
    n = 0;
    while (xcmd.start !== 1'b1 && n < 300)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 300)
    begin
      err_count++;
      finish_test();
    end
    chk({31'h0, xcmd.dwe}, 32'h1);
    chk(xcmd.desc_addr, 32'h100);
    wb(1'b1, 8'h00, 32'h0, 4'hf);
    @(negedge core_clk);
    chk({31'h0, xcmd.hold}, 32'h1);
    rdchk(8'h04, 32'h400);
    wb(1'b1, 8'h00, 32'h1, 4'hf);
    wait_idle();
    rdchk(8'h04, 32'h200);
    wb(1'b1, 8'h04, 32'hffff_ffff, 4'hf);
    lat <= 4'($urandom % 4);
    desc(32'h300, 32'h0, 32'h0, 32'h1);
    i_mem.mem[8'h40] = 32'h300;
    wb(1'b1, 8'h00, 32'h3, 4'hf);
    wait_idle();
    rdchk(8'h08, 32'h300);
    rdchk(8'h04, 32'h200);
    wb(1'b1, 8'h04, 32'hffff_ffff, 4'hf);
    for (int e = 1; e < 4; e++)
    begin
      desc(32'h100, 32'h200, 32'h40, 32'h8000_0001);
      desc(32'h200, 32'h0, 32'h0, 32'h1);
      mem_err <= (e == 1) ? 2'h1 : (e == 3) ? 2'h2 : 2'h0;
      mv_err <= (e == 2) ? 2'h1 : 2'h0;
      start(32'h100);
      wait_idle();
      rdchk(8'h04, (e < 3) ? 32'h20 : 32'h0);
      rdchk(8'h08, 32'h100);
      rdchk(8'h00, 32'h0);
      chk({31'h0, irq}, {31'h0, e < 3});
      mem_err <= 2'h0;
      mv_err <= 2'h0;
      wb(1'b1, 8'h04, 32'hffff_ffff, 4'hf);
    end
    finish_test();
  end
endmodule : accel_chain_status_irq_control_bench

`default_nettype wire
